/* hw/fpb_defines.svh */
// Constants for the serial flash page buffer and status command block
`ifndef FPB_DEFINES_SVH
`define FPB_DEFINES_SVH

// ==========================================================
// Opcodes
`define FPB_OP_XFER_B1   8'h53
`define FPB_OP_XFER_B2   8'h55
`define FPB_OP_COMP_B1   8'h60
`define FPB_OP_COMP_B2   8'h61
`define FPB_OP_REWR_B1   8'h58
`define FPB_OP_REWR_B2   8'h59
`define FPB_OP_STATUS    8'hD7

// ==========================================================
// Status fields
`define FPB_ST1_RDY      7
`define FPB_ST1_COMP     6
`define FPB_ST1_PROT     1
`define FPB_ST1_PGSZ     0
`define FPB_ST2_RDY      7
`define FPB_ST2_EPE      5
`define FPB_DENSITY      4'h7
`define FPB_COMP_RST     1'h0
`define FPB_EPE_RST      1'h0

// ==========================================================
// Frame bit positions, counted from zero on rising link clock edges
`define FPB_FRAME_FIRST  6'h00
`define FPB_OPC_LAST     6'h07
`define FPB_ADDR_LAST    6'h1F
`define FPB_DATA_LAST    6'h27
`define FPB_DATA_END     6'h28
`define FPB_STAT_LEN     6'h18
`define FPB_CMD_LEN      6'h20
`define FPB_RMW_LEN      6'h28
`define FPB_BYTE_LAST    3'h7

// ==========================================================
// Timing
`define FPB_CLK_MHZ      10
`define FPB_XFR_US       200
`define FPB_COMP_US      200
`define FPB_EP_US        40000
`define FPB_XFR_CYC      (`FPB_XFR_US * `FPB_CLK_MHZ)
`define FPB_COMP_CYC     (`FPB_COMP_US * `FPB_CLK_MHZ)
`define FPB_EP_CYC       (`FPB_EP_US * `FPB_CLK_MHZ)
`define FPB_HALF_CYC     2'h3

`endif

/* hw/fpb_device.sv */
// Flash device end: page buffer transfer, compare, rewrite and status read
//
// Contract
// - Opcode 53h buffer one, 55h buffer two
// - 264 layout: four dummy, page, nine dummy
// - 256 transfer page in address bits 18:8
// - Transfer starts on select rise, busy meanwhile
// - Compare opcodes 60h and 61h, three address
// - 256 compare page in address bits 18:8
// - Compare busy, result lands in bit six
// - Compare bit zero match, one differs
// - Rewrite opcodes 58h and 59h
// - 264 rewrite: two dummy, twelve page bits
// - 256 rewrite page in address bits 20:9
// - Rewrite copies then programs back, busy
// - Trailing data bytes make read-modify-write
// - Host refreshes static pages within endurance
// - Opcode D7h streams status, even busy
// - Status repeats after two bytes, resampled
// - Ready bit fresh in both bytes
// - Select rise ends read, output floats
// - Bit seven zero busy, one ready
// - Bits five to two read 0111
// - Bit one shows sector protection
// - Bit zero shows page size, selects layout
// - Byte two bit five erase/program error
`timescale 1ns/1ns
`include "fpb_defines.svh"
module fpb_device import fpb_pkg::*; #(
    parameter int XFR_CYC  = `FPB_XFR_CYC,
    parameter int COMP_CYC = `FPB_COMP_CYC,
    parameter int EP_CYC   = `FPB_EP_CYC
) (
    // Core clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // Array state
    input  wire logic        page_size_256_in,
    input  wire logic        protect_in,
    input  wire logic        page_differs_in,
    input  wire logic        erase_program_error_in,
    // Array operation request
    output logic             op_start_out,
    output fpb_op_kind_t     op_kind_out,
    output logic             op_buf2_out,
    output logic [11:0]      op_page_out,
    output logic             op_rmw_out,
    output logic             busy_out,
    // Serial link
    fpb_if.dev               bus
);

    // ==========================================================
    // Decode helpers
    function automatic fpb_op_kind_t fpb_kind(input logic [7:0] opc);
        if (opc == `FPB_OP_XFER_B1 || opc == `FPB_OP_XFER_B2) begin
            fpb_kind = kind_xfer;
        end else if (opc == `FPB_OP_COMP_B1 || opc == `FPB_OP_COMP_B2) begin
            fpb_kind = kind_comp;
        end else if (opc == `FPB_OP_REWR_B1 || opc == `FPB_OP_REWR_B2) begin
            fpb_kind = kind_rewr;
        end else begin
            fpb_kind = kind_none;
        end
    endfunction : fpb_kind

    function automatic logic fpb_buf2(input logic [7:0] opc);
        fpb_buf2 = (opc == `FPB_OP_XFER_B2) || (opc == `FPB_OP_COMP_B2) ||
                   (opc == `FPB_OP_REWR_B2);
    endfunction : fpb_buf2

    // Layouts are decoded as printed, including the odd 256-byte leads
    function automatic logic [11:0] fpb_page(input fpb_op_kind_t k, input logic p256,
                                             input logic [23:0] a);
        if (k == kind_rewr) begin
            fpb_page = p256 ? a[20:9] : a[21:10];
        end else begin
            fpb_page = p256 ? {1'b0, a[18:8]} : {1'b0, a[19:9]};
        end
    endfunction : fpb_page

    // ==========================================================
    // Link side, clocked by the host serial clock
    logic [5:0]  bit_cnt_r;
    logic [31:0] cmd_sh_r;
    logic [7:0]  opcode_r;
    logic [23:0] addr_r;
    logic        cmd_seen_r;
    logic        data_seen_r;
    logic        rd_mode_r;
    logic [7:0]  st_sh_r;
    logic [2:0]  st_cnt_r;
    logic        st_next2_r;
    logic [15:0] st_link;
    logic [7:0]  opc_now;
    logic [15:0] status_r;

    assign opc_now = {cmd_sh_r[6:0], bus.si};

    fpb_sync2 #(.WIDTH(16)) u_st_sync (
        .clock_in (bus.sck),
        .d_in     (status_r),
        .q_out    (st_link)
    );

    // Select high clears the frame even without a clock edge
    always_ff @(posedge bus.sck or posedge bus.cs_n) begin
        if (bus.cs_n) begin
            bit_cnt_r <= 6'h00;
        end else if (bit_cnt_r != `FPB_DATA_END) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
        end
    end

    always_ff @(posedge bus.sck) begin
        cmd_sh_r <= {cmd_sh_r[30:0], bus.si};
    end

    // Fields hold while select is high so the core side can read them
    always_ff @(posedge bus.sck) begin
        if (bit_cnt_r == `FPB_OPC_LAST) begin
            opcode_r <= opc_now;
        end
        if (bit_cnt_r == `FPB_ADDR_LAST) begin
            addr_r <= {cmd_sh_r[22:0], bus.si};
        end
    end

    // A flag marks a complete opcode and address, so short frames do nothing;
    // it needs no reset because every frame clears it on its first edge
    always_ff @(posedge bus.sck) begin
        if (bit_cnt_r == `FPB_FRAME_FIRST) begin
            cmd_seen_r  <= 1'b0;
        end else if (bit_cnt_r == `FPB_ADDR_LAST) begin
            cmd_seen_r  <= 1'b1;
            data_seen_r <= 1'b0;
        end else if (bit_cnt_r == `FPB_DATA_LAST) begin
            data_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge bus.sck or posedge bus.cs_n) begin
        if (bus.cs_n) begin
            rd_mode_r <= 1'b0;
        end else if (bit_cnt_r == `FPB_OPC_LAST && opc_now == `FPB_OP_STATUS) begin
            rd_mode_r <= 1'b1;
        end
    end

    always_ff @(posedge bus.sck) begin
        if (bit_cnt_r == `FPB_OPC_LAST) begin
            st_sh_r    <= st_link[15:8];
            st_cnt_r   <= 3'h0;
            st_next2_r <= 1'b1;
        end else if (st_cnt_r == `FPB_BYTE_LAST) begin
            st_sh_r    <= st_next2_r ? st_link[7:0] : st_link[15:8];
            st_cnt_r   <= 3'h0;
            st_next2_r <= ~st_next2_r;
        end else begin
            st_sh_r    <= {st_sh_r[6:0], 1'b0};
            st_cnt_r   <= st_cnt_r + 3'h1;
        end
    end

    assign bus.so    = st_sh_r[7];
    assign bus.so_oe = rd_mode_r & ~bus.cs_n;

    // ==========================================================
    // Core side: select-rise detection
    logic         cs_s;
    logic         cs_d_r;
    logic         cs_rise;
    logic         new_cmd;
    fpb_op_kind_t new_kind;

    fpb_sync2 #(.WIDTH(1)) u_cs_sync (
        .clock_in (clock_in),
        .d_in     (bus.cs_n),
        .q_out    (cs_s)
    );

    assign cs_rise  = cs_s & ~cs_d_r;
    assign new_cmd  = cs_rise && cmd_seen_r;
    assign new_kind = fpb_kind(opcode_r);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cs_d_r <= 1'b1;
        end else if (ce_in) begin
            cs_d_r <= cs_s;
        end
    end

    // ==========================================================
    // Core side: operation sequencer
    fpb_op_state_t state_r;
    logic [19:0]   cnt_r;
    logic          pg256_r;
    logic          comp_r;
    logic          epe_r;

    // The page-size strap is caught while reset is held
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pg256_r <= page_size_256_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r      <= op_idle;
            cnt_r        <= 20'h0_0000;
            op_start_out <= 1'b0;
            op_kind_out  <= kind_none;
            op_buf2_out  <= 1'b0;
            op_page_out  <= 12'h000;
            op_rmw_out   <= 1'b0;
        end else if (ce_in) begin
            op_start_out <= 1'b0;
            case (state_r)
                op_idle: begin
                    // Commands arriving while busy are dropped, status reads are not
                    if (new_cmd && new_kind != kind_none) begin
                        state_r      <= op_run;
                        op_start_out <= 1'b1;
                        op_kind_out  <= new_kind;
                        op_buf2_out  <= fpb_buf2(opcode_r);
                        op_page_out  <= fpb_page(new_kind, pg256_r, addr_r);
                        op_rmw_out   <= (new_kind == kind_rewr) && data_seen_r;
                        if (new_kind == kind_xfer) begin
                            cnt_r <= 20'(XFR_CYC);
                        end else if (new_kind == kind_comp) begin
                            cnt_r <= 20'(COMP_CYC);
                        end else begin
                            cnt_r <= 20'(EP_CYC);
                        end
                    end
                end
                op_run: begin
                    if (cnt_r <= 20'h0_0001) begin
                        state_r <= op_idle;
                    end else begin
                        cnt_r <= cnt_r - 20'h0_0001;
                    end
                end
                default: begin
                    state_r <= op_idle;
                end
            endcase
        end
    end

    // Results are taken from the array as the operation finishes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            comp_r <= `FPB_COMP_RST;
            epe_r  <= `FPB_EPE_RST;
        end else if (ce_in && state_r == op_run && cnt_r <= 20'h0_0001) begin
            if (op_kind_out == kind_comp) begin
                comp_r <= page_differs_in;
            end
            if (op_kind_out == kind_rewr) begin
                epe_r <= erase_program_error_in;
            end
        end
    end

    assign busy_out = state_r[1];

    // ==========================================================
    // Status bytes, refreshed every clock-enabled cycle for the link side to sample
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            status_r <= 16'h0000;
        end else if (ce_in) begin
            status_r                   <= 16'h0000;
            status_r[8+`FPB_ST1_RDY]   <= ~state_r[1];
            status_r[8+`FPB_ST1_COMP]  <= comp_r;
            status_r[13:10]            <= `FPB_DENSITY;
            status_r[8+`FPB_ST1_PROT]  <= protect_in;
            status_r[8+`FPB_ST1_PGSZ]  <= pg256_r;
            status_r[`FPB_ST2_RDY]     <= ~state_r[1];
            status_r[`FPB_ST2_EPE]     <= epe_r;
        end
    end

endmodule : fpb_device

/* hw/fpb_host.sv */
// Host end: frames commands onto the serial link and collects status
`timescale 1ns/1ns
`include "fpb_defines.svh"
module fpb_host import fpb_pkg::*; (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // Command port
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_opcode_in,
    input  wire logic [23:0] cmd_addr_in,
    input  wire logic        cmd_with_data_in,
    input  wire logic [7:0]  cmd_data_in,
    output logic             cmd_ready_out,
    // Status answer
    output logic [15:0]      status_out,
    output logic             status_valid_out,
    // Serial link
    fpb_if.host              bus
);

    // ==========================================================
    // Frame state
    fpb_host_state_t state_r;
    logic [1:0]      div_r;
    logic [5:0]      bit_r;
    logic [5:0]      len_r;
    logic [39:0]     tx_r;
    logic [15:0]     rx_r;
    logic            is_stat_r;
    logic            sck_r;
    logic            cs_n_r;
    logic            si_r;
    logic            so_s;

    fpb_sync2 #(.WIDTH(1)) u_so_sync (
        .clock_in (clock_in),
        .d_in     (bus.so_line),
        .q_out    (so_s)
    );

    assign bus.sck  = sck_r;
    assign bus.cs_n = cs_n_r;
    assign bus.si   = si_r;

    // ==========================================================
    // Mode 0 framing: data set while the clock is low, sampled on its rise
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r          <= h_idle;
            div_r            <= 2'h0;
            bit_r            <= 6'h00;
            len_r            <= 6'h00;
            tx_r             <= 40'h00_0000_0000;
            rx_r             <= 16'h0000;
            is_stat_r        <= 1'b0;
            sck_r            <= 1'b0;
            cs_n_r           <= 1'b1;
            si_r             <= 1'b0;
            cmd_ready_out    <= 1'b1;
            status_out       <= 16'h0000;
            status_valid_out <= 1'b0;
        end else if (ce_in) begin
            status_valid_out <= 1'b0;
            case (state_r)
                h_idle: begin
                    if (cmd_valid_in && cmd_ready_out) begin
                        cmd_ready_out <= 1'b0;
                        cs_n_r        <= 1'b0;
                        tx_r          <= {cmd_opcode_in, cmd_addr_in, cmd_data_in};
                        si_r          <= cmd_opcode_in[7];
                        is_stat_r     <= (cmd_opcode_in == `FPB_OP_STATUS);
                        if (cmd_opcode_in == `FPB_OP_STATUS) begin
                            len_r <= `FPB_STAT_LEN;
                        end else if (cmd_with_data_in) begin
                            len_r <= `FPB_RMW_LEN;
                        end else begin
                            len_r <= `FPB_CMD_LEN;
                        end
                        bit_r   <= 6'h00;
                        div_r   <= 2'h0;
                        state_r <= h_low;
                    end
                end
                h_low: begin
                    if (div_r == `FPB_HALF_CYC) begin
                        div_r   <= 2'h0;
                        sck_r   <= 1'b1;
                        state_r <= h_high;
                        if (is_stat_r && bit_r > `FPB_OPC_LAST) begin
                            rx_r <= {rx_r[14:0], so_s};
                        end
                    end else begin
                        div_r <= div_r + 2'h1;
                    end
                end
                h_high: begin
                    if (div_r == `FPB_HALF_CYC) begin
                        div_r <= 2'h0;
                        sck_r <= 1'b0;
                        if (bit_r == len_r - 6'h01) begin
                            cs_n_r           <= 1'b1;
                            status_out       <= rx_r;
                            status_valid_out <= is_stat_r;
                            state_r          <= h_gap;
                        end else begin
                            bit_r   <= bit_r + 6'h01;
                            tx_r    <= {tx_r[38:0], 1'b0};
                            si_r    <= tx_r[38];
                            state_r <= h_low;
                        end
                    end else begin
                        div_r <= div_r + 2'h1;
                    end
                end
                h_gap: begin
                    // Keeps select high for a full half period between frames
                    if (div_r == `FPB_HALF_CYC) begin
                        div_r         <= 2'h0;
                        cmd_ready_out <= 1'b1;
                        state_r       <= h_idle;
                    end else begin
                        div_r <= div_r + 2'h1;
                    end
                end
                default: begin
                    state_r <= h_idle;
                end
            endcase
        end
    end

endmodule : fpb_host

/* hw/fpb_if.sv */
// Serial link between host controller and flash device
`timescale 1ns/1ns
interface fpb_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    // A released output shows the inverse of its last bit, so late sampling shows up
    assign so_line = so_oe ? so : ~so;

    modport host (output sck, output cs_n, output si, input so_line);
    modport dev  (input sck, input cs_n, input si, output so, output so_oe);
endinterface : fpb_if

/* hw/fpb_pkg.sv */
// Types shared by both ends of the serial flash command link
package fpb_pkg;

    // ==========================================================
    // Device operation sequencer
    typedef enum logic [1:0] {
        op_idle = 2'b01,
        op_run  = 2'b10
    } fpb_op_state_t;

    typedef enum logic [1:0] {
        kind_xfer = 2'b00,
        kind_comp = 2'b01,
        kind_rewr = 2'b10,
        kind_none = 2'b11
    } fpb_op_kind_t;

    // ==========================================================
    // Host frame sequencer
    typedef enum logic [3:0] {
        h_idle = 4'b0001,
        h_low  = 4'b0010,
        h_high = 4'b0100,
        h_gap  = 4'b1000
    } fpb_host_state_t;

endpackage : fpb_pkg

/* hw/fpb_sync2.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module fpb_sync2 #(
    parameter int WIDTH = 1
) (
    // Destination clock
    input  wire logic             clock_in,
    // Level to cross
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clock_in) begin
        meta_r <= d_in;
        q_out  <= meta_r;
    end
endmodule : fpb_sync2

/* tb/fpb_link_sva.sv */
// Link checker for the serial flash command link
`timescale 1ns/1ns
module fpb_link_sva (
    // Core clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // Serial link
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic       sck_q;
    logic       cs_q;
    logic       rd;
    logic       rise;
    logic [7:0] cnt;
    logic [7:0] sh;
    logic [3:0] pos;

    assign rise = sck & ~sck_q;
    assign pos  = 4'(cnt - 8'h08);

    // ==========================================================
    // Bit tracker
    // Sampled on the core clock, as the host makes sck from it
    always_ff @(posedge clock_in) begin
        sck_q <= sck;
        cs_q  <= cs_n;
    end
    always_ff @(posedge clock_in) begin
        if (cs_q && !cs_n) cnt <= 8'h00;
        else if (rise && cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
    always_ff @(posedge clock_in) begin
        if (rise) sh <= {sh[6:0], si};
    end
    always_ff @(posedge clock_in) begin
        if (cs_q && !cs_n) rd <= 1'b0;
        else if (rise && cnt == 8'h07) rd <= ({sh[6:0], si} == 8'hD7);
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_float_deselect: assert property (cs_n |-> !so_oe)
        else $error("so_oe high while deselected");
    a_sck_idle: assert property (cs_n |-> !sck)
        else $error("sck not idle low outside frame");
    a_frame_len: assert property (cs_n && !cs_q |-> cnt inside {8'h18, 8'h20, 8'h28})
        else $error("frame bit count wrong");
    a_select_gap: assert property (cs_n && !cs_q |-> cs_n [*4])
        else $error("select gap too short");
    a_status_drive: assert property (rd && !cs_n && !cs_q |-> so_oe)
        else $error("status not driven");
    a_density_code: assert property (rd && !cs_n && !cs_q && !rise && pos inside {[2:5]}
        |-> so == (pos != 4'h2)) else $error("density bit wrong");
    a_byte2_zero: assert property (rd && !cs_n && !cs_q && !rise
        && pos inside {4'h9, [11:15]} |-> !so) else $error("byte two reserved bit set");
    a_so_steady: assert property (so_oe && $past(so_oe) && !rise |-> $stable(so))
        else $error("so moved without sck rise");
endmodule : fpb_link_sva

/* tb/tb_top.sv */
// Self-checking bench for host and device ends joined on the link
`timescale 1ns/1ns
module tb_top;
    logic        clock_in;
    logic        rst_in;
    logic        ce;
    logic        pg256;
    logic        prot;
    logic        differs;
    logic        erase_program_error_flag;
    logic        valid;
    logic [7:0]  opc;
    logic [23:0] addr;
    logic        wd;
    logic        ready;
    logic [15:0] stat;
    logic        stat_v;
    logic        start;
    logic [1:0]  kind;
    logic        buf2;
    logic [11:0] page;
    logic        rmw;
    logic        busy;
    int          fail_count;
    int          n_compared;

    fpb_if link ();
    fpb_host fpb_host_i (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce),
        .cmd_valid_in(valid), .cmd_opcode_in(opc), .cmd_addr_in(addr),
        .cmd_with_data_in(wd), .cmd_data_in(8'hA5), .cmd_ready_out(ready),
        .status_out(stat), .status_valid_out(stat_v), .bus(link));
    // Short durations keep the run brief; rewrite stays longer than a status frame
    fpb_device #(.XFR_CYC(20), .COMP_CYC(20), .EP_CYC(400)) fpb_device_i (
        .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce), .page_size_256_in(pg256),
        .protect_in(prot), .page_differs_in(differs), .erase_program_error_in(erase_program_error_flag),
        .op_start_out(start), .op_kind_out(kind), .op_buf2_out(buf2), .op_page_out(page),
        .op_rmw_out(rmw), .busy_out(busy), .bus(link));
    fpb_link_sva fpb_link_sva_i (.clock_in(clock_in), .rst_in(rst_in), .sck(link.sck),
        .cs_n(link.cs_n), .si(link.si), .so(link.so), .so_oe(link.so_oe));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk
    task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig !== lvl && n < lim) begin
            @(negedge clock_in);
            n++;
        end
        chk("wait", {15'h0000, lvl}, {15'h0000, sig});
    endtask : wait_lvl
    task automatic issue(input logic [7:0] op, input logic [23:0] ad, input logic dat);
        wait_lvl(ready, 1'b1, 2000);
        opc = op;
        addr = ad;
        wd = dat;
        valid = 1'b1;
        @(negedge clock_in);
        valid = 1'b0;
    endtask : issue
    task automatic status(input logic [15:0] exp);
        issue(8'hD7, 24'h00_0000, 1'b0);
        wait_lvl(stat_v, 1'b1, 400);
        chk("status", exp, stat);
    endtask : status
    task automatic do_op(input logic [7:0] op, input logic [23:0] ad, input logic dat,
                         input logic [15:0] exp, input logic hold);
        issue(op, ad, dat);
        wait_lvl(start, 1'b1, 600);
        chk("operation", exp, {kind, buf2, rmw, page});
        @(negedge clock_in);
        chk("busy", 16'h0001, {15'h0000, busy});
        if (!hold) wait_lvl(busy, 1'b0, 1000);
    endtask : do_op
    task automatic do_reset(input logic size);
        rst_in = 1'b1;
        pg256 = size;
        // Two edges fill the select synchroniser; unknown opcodes decode as no command
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
    endtask : do_reset
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    // ==========================================================
    // Tests
    initial begin
        #2_000_000;
        fail_count++;
        finish_test();
    end
    initial begin
        rst_in = 1'b1;
        ce = 1'b1;
        pg256 = 1'b0;
        prot = 1'b1;
        differs = 1'b0;
        erase_program_error_flag = 1'b0;
        valid = 1'b0;
        opc = 8'h00;
        addr = 24'h00_0000;
        wd = 1'b0;
        fail_count = 0;
        n_compared = 0;
        do_reset(1'b0);
        status(16'h9E80);
        do_op(8'h53, {4'hF, 11'h5A5, 9'h1FF}, 1'b0, {4'h0, 12'h5A5}, 1'b0);
        do_op(8'h55, {4'h0, 11'h2DB, 9'h000}, 1'b0, {4'h2, 12'h2DB}, 1'b0);
        do_op(8'h60, {4'hA, 11'h7FF, 9'h155}, 1'b0, {4'h4, 12'h7FF}, 1'b1);
        // Clock enable low must keep the short compare busy past its length
        ce = 1'b0;
        repeat (40) @(negedge clock_in);
        chk("frozen busy", 16'h0001, {15'h0000, busy});
        ce = 1'b1;
        wait_lvl(busy, 1'b0, 1000);
        status(16'h9E80);
        differs = 1'b1;
        do_op(8'h61, {4'h5, 11'h001, 9'h0AA}, 1'b0, {4'h6, 12'h001}, 1'b0);
        status(16'hDE80);
        erase_program_error_flag = 1'b1;
        do_op(8'h58, {2'h3, 12'hA5C, 10'h3FF}, 1'b0, {4'h8, 12'hA5C}, 1'b0);
        erase_program_error_flag = 1'b0;
        do_op(8'h59, {2'h0, 12'h3A5, 10'h000}, 1'b1, {4'hB, 12'h3A5}, 1'b1);
        status(16'h5E20);
        wait_lvl(busy, 1'b0, 1000);
        status(16'hDE80);
        prot = 1'b0;
        do_reset(1'b1);
        status(16'h9D80);
        do_op(8'h53, {5'h1F, 11'h4B3, 8'hFF}, 1'b0, {4'h0, 12'h4B3}, 1'b0);
        do_op(8'h61, {5'h00, 11'h6C9, 8'h00}, 1'b0, {4'h6, 12'h6C9}, 1'b0);
        do_op(8'h59, {3'h7, 12'hC3A, 9'h1FF}, 1'b0, {4'hA, 12'hC3A}, 1'b0);
        finish_test();
    end
endmodule : tb_top
